/* src/mbam_pkg.sv */
// Notes on behaviour
// - The program counter is thirteen bits wide and so spans eight thousand instruction words.
// - Only program words 0000h-03FFh (small variant) or 0000h-07FFh (large variant) exist.
// - A fetch above the implemented size wraps onto the implemented region.
// - Fetching starts at 0000h after reset and jumps to 0004h when an interrupt is taken.
// - Status bit 5 selects bank 1 for direct accesses when one and bank 0 when zero.
// - Each bank holds 128 offsets, so a direct address is the bank bit plus seven offset bits.
// - The low offsets of each bank are special registers; above them bank 0 is all static RAM, bank 1 only A0h-BFh and F0h-FFh.
// - Indirect slot, counter low byte, status, pointer, counter high latch and interrupt control
//       sit at the same offset in both banks and share one storage location.
// - Bank 1 addresses F0h-FFh reach the same RAM as bank 0 addresses 70h-7Fh.
// - Every file location is reachable directly or through the indirect pointer.
// - Unimplemented data addresses read as zero and ignore writes.
// - The operand read happens in the second quarter and the destination write in the fourth.
package mbam_pkg;
  localparam int         PC_W          = 13;
  localparam logic [12:0] PROG_MASK_SMALL = 13'h03FF;
  localparam logic [12:0] PROG_MASK_LARGE = 13'h07FF;
  localparam logic [12:0] RESET_VEC     = 13'h0000;
  localparam logic [12:0] IRQ_VEC       = 13'h0004;
  localparam logic [12:0] PC_STEP       = 13'h0001;
  localparam logic [12:0] PC_TOP        = 13'h1FFF;
  localparam int         OFS_W         = 7;
  localparam int         BANK_BIT      = 5;
  localparam int         PC_HIGH_LATCH_W      = 5;
  localparam int         RAM_DEPTH     = 128;
  localparam int         RAM_IDX_W     = 7;
  // mirrored core offsets, decoded on the seven offset bits
  localparam logic [6:0] OFS_INDIRECT  = 7'h00;
  localparam logic [6:0] OFS_PCL       = 7'h02;
  localparam logic [6:0] OFS_STATUS    = 7'h03;
  localparam logic [6:0] OFS_FSR       = 7'h04;
  localparam logic [6:0] OFS_PC_HIGH_LATCH    = 7'h0A;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL    = 7'h0B;
  // peripheral registers, decoded on the full address
  localparam logic [7:0] ADDR_TIMER    = 8'h01;
  localparam logic [7:0] ADDR_PORT     = 8'h05;
  localparam logic [7:0] ADDR_PIRQ_FLG = 8'h0C;
  localparam logic [7:0] ADDR_ARESULT  = 8'h1E;
  localparam logic [7:0] ADDR_ACTRL_A  = 8'h1F;
  localparam logic [7:0] ADDR_TOPTIONS = 8'h81;
  localparam logic [7:0] ADDR_PINDIR   = 8'h85;
  localparam logic [7:0] ADDR_PIRQ_EN  = 8'h8C;
  localparam logic [7:0] ADDR_PWRCTL   = 8'h8E;
  localparam logic [7:0] ADDR_OSCTRIM  = 8'h8F;
  localparam logic [7:0] ADDR_ACTRL_B  = 8'h9F;
  // general purpose RAM windows
  localparam logic [7:0] GPR0_LO       = 8'h20;
  localparam logic [7:0] GPR0_HI       = 8'h7F;
  localparam logic [7:0] GPR1_LO       = 8'hA0;
  localparam logic [7:0] GPR1_HI       = 8'hBF;
  localparam logic [7:0] COMMON_LO     = 8'hF0;
  localparam logic [7:0] COMMON_HI     = 8'hFF;
  localparam logic [7:0] GPR1_IDX_BASE = 8'h60;
  localparam logic [7:0] COMMON_IDX_BASE = 8'h50;
  // reset values and write masks
  localparam logic [7:0] STATUS_RST    = 8'h18;
  localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [4:0] PC_HIGH_LATCH_RST    = 5'h00;

  typedef enum logic [1:0] {
    MBAM_Q1 = 2'b00,
    MBAM_Q2 = 2'b01,
    MBAM_Q3 = 2'b10,
    MBAM_Q4 = 2'b11
  } mbam_phase_e;
endpackage : mbam_pkg

/* src/mbam_gpr.sv */
`timescale 1ns/1ns
// general purpose static RAM, shared by both banks and the common window
module mbam_gpr (
  // clock
  input  wire logic       clk,
  // write side
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_idx,
  input  wire logic [7:0] wr_data,
  // read side, combinational so the caller decides the capture quarter
  input  wire logic [6:0] rd_idx,
  output logic      [7:0] rd_data
);
  logic [7:0] mem [mbam_pkg::RAM_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // contents power up undefined, as static RAM does
  assign rd_data = mem[rd_idx];
endmodule : mbam_gpr

/* src/mbam_top.sv */
`timescale 1ns/1ns
module mbam_top #(
  parameter bit LARGE_PROG = 1'b1
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // program fetch
  input  wire logic        JUMP_REQ,
  input  wire logic [10:0] JUMP_ADDR,
  input  wire logic        IRQ_TAKE,
  output logic      [12:0] PROG_ADDR,
  output logic             FETCH_STB,
  output logic      [1:0]  PHASE_Q,
  // data file access from the core
  input  wire logic [6:0]  FILE_ADDR,
  input  wire logic        FILE_WE,
  input  wire logic [7:0]  FILE_WDATA,
  output logic      [7:0]  FILE_RDATA,
  output logic             BANK_SEL,
  // peripheral register port
  input  wire logic [7:0]  PERI_RDATA,
  output logic      [7:0]  PERI_ADDR,
  output logic             PERI_WE,
  output logic      [7:0]  PERI_WDATA
);
  localparam logic [12:0] PROG_MASK =
    LARGE_PROG ? mbam_pkg::PROG_MASK_LARGE : mbam_pkg::PROG_MASK_SMALL;

  typedef enum logic [2:0] {
    MBAM_T_NONE   = 3'b000,
    MBAM_T_CORE   = 3'b001,
    MBAM_T_PERI   = 3'b010,
    MBAM_T_PERIRO = 3'b011,
    MBAM_T_RAM    = 3'b100
  } mbam_target_e;

  mbam_pkg::mbam_phase_e phase_reg, phase_next;
  logic [12:0] pc_reg, pc_next;
  logic [12:0] prog_addr_reg, prog_addr_next;
  logic        fetch_reg, fetch_next;
  logic [7:0]  status_reg, status_next;
  logic [7:0]  fsr_reg, fsr_next;
  logic [4:0]  pc_high_latch_reg, pc_high_latch_next;
  logic [7:0]  interrupt_control_reg, interrupt_control_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [7:0]  peri_addr_reg, peri_addr_next;
  logic        peri_we_reg, peri_we_next;
  logic [7:0]  peri_wdata_reg, peri_wdata_next;

  logic [7:0]   eff_addr;
  logic [6:0]   eff_ofs;
  mbam_target_e target;
  logic [6:0]   ram_idx;
  logic [7:0]   ram_rdata;
  logic [7:0]   read_val;
  logic         ram_we;
  logic         write_now;
  logic         read_now;

  // quarter sequencer: one instruction cycle is four clocks
  always_comb begin
    unique case (phase_reg)
      mbam_pkg::MBAM_Q1: phase_next = mbam_pkg::MBAM_Q2;
      mbam_pkg::MBAM_Q2: phase_next = mbam_pkg::MBAM_Q3;
      mbam_pkg::MBAM_Q3: phase_next = mbam_pkg::MBAM_Q4;
      mbam_pkg::MBAM_Q4: phase_next = mbam_pkg::MBAM_Q1;
    endcase
    if (SRST) begin
      phase_next = mbam_pkg::MBAM_Q1;
    end
  end

  always_ff @(posedge CLK) begin
    phase_reg <= phase_next;
  end

  assign read_now  = (phase_reg == mbam_pkg::MBAM_Q2);
  assign write_now = (phase_reg == mbam_pkg::MBAM_Q4) && FILE_WE;

  // address formation: offset 00h redirects through the pointer
  always_comb begin
    if (FILE_ADDR == mbam_pkg::OFS_INDIRECT) begin
      eff_addr = fsr_reg;
    end else begin
      eff_addr = {status_reg[mbam_pkg::BANK_BIT], FILE_ADDR};
    end
    eff_ofs = eff_addr[mbam_pkg::OFS_W-1:0];
  end

  // decode of the effective address
  always_comb begin
    target  = MBAM_T_NONE;
    ram_idx = '0;
    if (eff_ofs == mbam_pkg::OFS_PCL || eff_ofs == mbam_pkg::OFS_STATUS ||
        eff_ofs == mbam_pkg::OFS_FSR || eff_ofs == mbam_pkg::OFS_PC_HIGH_LATCH ||
        eff_ofs == mbam_pkg::OFS_INTERRUPT_CONTROL) begin
      target = MBAM_T_CORE;
    end else if (eff_addr == mbam_pkg::ADDR_ARESULT) begin
      target = MBAM_T_PERIRO;
    end else if (eff_addr == mbam_pkg::ADDR_TIMER || eff_addr == mbam_pkg::ADDR_PORT ||
                 eff_addr == mbam_pkg::ADDR_PIRQ_FLG || eff_addr == mbam_pkg::ADDR_ACTRL_A ||
                 eff_addr == mbam_pkg::ADDR_TOPTIONS || eff_addr == mbam_pkg::ADDR_PINDIR ||
                 eff_addr == mbam_pkg::ADDR_PIRQ_EN || eff_addr == mbam_pkg::ADDR_PWRCTL ||
                 eff_addr == mbam_pkg::ADDR_OSCTRIM || eff_addr == mbam_pkg::ADDR_ACTRL_B) begin
      target = MBAM_T_PERI;
    end else if (eff_addr >= mbam_pkg::GPR0_LO && eff_addr <= mbam_pkg::GPR0_HI) begin
      target  = MBAM_T_RAM;
      ram_idx = 7'(eff_addr - mbam_pkg::GPR0_LO);
    end else if (eff_addr >= mbam_pkg::GPR1_LO && eff_addr <= mbam_pkg::GPR1_HI) begin
      target  = MBAM_T_RAM;
      ram_idx = 7'(eff_addr - mbam_pkg::GPR1_LO + mbam_pkg::GPR1_IDX_BASE);
    end else if (eff_addr >= mbam_pkg::COMMON_LO) begin
      target  = MBAM_T_RAM;
      ram_idx = 7'(eff_addr - mbam_pkg::COMMON_LO + mbam_pkg::COMMON_IDX_BASE);
    end
  end

  assign ram_we = write_now && (target == MBAM_T_RAM);

  mbam_gpr u_gpr (
    .clk     (CLK),
    .wr_en   (ram_we),
    .wr_idx  (ram_idx),
    .wr_data (FILE_WDATA),
    .rd_idx  (ram_idx),
    .rd_data (ram_rdata)
  );

  // read multiplexer; a pointer aimed at 00h lands in MBAM_T_NONE and reads zero
  always_comb begin
    unique case (target)
      MBAM_T_CORE: begin
        unique case (eff_ofs)
          mbam_pkg::OFS_PCL:    read_val = pc_reg[7:0];
          mbam_pkg::OFS_STATUS: read_val = status_reg;
          mbam_pkg::OFS_FSR:    read_val = fsr_reg;
          mbam_pkg::OFS_PC_HIGH_LATCH: read_val = {3'h0, pc_high_latch_reg};
          default:              read_val = interrupt_control_reg;
        endcase
      end
      MBAM_T_PERI,
      MBAM_T_PERIRO: read_val = PERI_RDATA;
      MBAM_T_RAM:    read_val = ram_rdata;
      default:       read_val = mbam_pkg::BYTE_ZERO;
    endcase
  end

  // program counter group
  always_comb begin
    pc_next = pc_reg;
    if (phase_reg == mbam_pkg::MBAM_Q4) begin
      if (IRQ_TAKE) begin
        pc_next = mbam_pkg::IRQ_VEC;
      end else if (write_now && target == MBAM_T_CORE && eff_ofs == mbam_pkg::OFS_PCL) begin
        pc_next = {pc_high_latch_reg, FILE_WDATA};
      end else if (JUMP_REQ) begin
        pc_next = {pc_high_latch_reg[4:3], JUMP_ADDR};
      end else begin
        pc_next = pc_reg + mbam_pkg::PC_STEP;
      end
    end
    if (SRST) begin
      pc_next = mbam_pkg::RESET_VEC;
    end
    prog_addr_next = pc_next & PROG_MASK;
    fetch_next     = !SRST && (phase_next == mbam_pkg::MBAM_Q4);
  end

  always_ff @(posedge CLK) begin
    pc_reg        <= pc_next;
    prog_addr_reg <= prog_addr_next;
    fetch_reg     <= fetch_next;
  end

  // core register and data path group
  always_comb begin
    status_next     = status_reg;
    fsr_next        = fsr_reg;
    pc_high_latch_next     = pc_high_latch_reg;
    interrupt_control_next     = interrupt_control_reg;
    rdata_next      = rdata_reg;
    // peripheral address trails by one clock, so it is settled before the quarter-2 capture
    peri_addr_next  = eff_addr;
    peri_wdata_next = FILE_WDATA;
    peri_we_next    = (phase_reg == mbam_pkg::MBAM_Q3) && FILE_WE &&
                      (target == MBAM_T_PERI);
    if (read_now) begin
      rdata_next = read_val;
    end
    if (write_now && target == MBAM_T_CORE) begin
      unique case (eff_ofs)
        mbam_pkg::OFS_STATUS: status_next = (status_reg & ~mbam_pkg::STATUS_WR_MASK) |
                                            (FILE_WDATA & mbam_pkg::STATUS_WR_MASK);
        mbam_pkg::OFS_FSR:    fsr_next    = FILE_WDATA;
        mbam_pkg::OFS_PC_HIGH_LATCH: pc_high_latch_next = FILE_WDATA[mbam_pkg::PC_HIGH_LATCH_W-1:0];
        mbam_pkg::OFS_INTERRUPT_CONTROL: interrupt_control_next = FILE_WDATA;
        default:              status_next = status_reg;
      endcase
    end
    if (SRST) begin
      status_next    = mbam_pkg::STATUS_RST;
      fsr_next       = mbam_pkg::BYTE_ZERO;
      pc_high_latch_next    = mbam_pkg::PC_HIGH_LATCH_RST;
      interrupt_control_next    = mbam_pkg::BYTE_ZERO;
      rdata_next     = mbam_pkg::BYTE_ZERO;
      peri_addr_next = mbam_pkg::BYTE_ZERO;
      peri_we_next   = 1'b0;
      peri_wdata_next = mbam_pkg::BYTE_ZERO;
    end
  end

  always_ff @(posedge CLK) begin
    status_reg     <= status_next;
    fsr_reg        <= fsr_next;
    pc_high_latch_reg     <= pc_high_latch_next;
    interrupt_control_reg     <= interrupt_control_next;
    rdata_reg      <= rdata_next;
    peri_addr_reg  <= peri_addr_next;
    peri_we_reg    <= peri_we_next;
    peri_wdata_reg <= peri_wdata_next;
  end

  assign PROG_ADDR  = prog_addr_reg;
  assign FETCH_STB  = fetch_reg;
  assign PHASE_Q    = phase_reg;
  assign FILE_RDATA = rdata_reg;
  assign BANK_SEL   = status_reg[mbam_pkg::BANK_BIT];
  assign PERI_ADDR  = peri_addr_reg;
  assign PERI_WE    = peri_we_reg;
  assign PERI_WDATA = peri_wdata_reg;

  // checks
  sequence s_q4_plain_step;
    phase_reg == mbam_pkg::MBAM_Q4 && !IRQ_TAKE && !JUMP_REQ && !FILE_WE;
  endsequence

  sequence s_q4_fsr_write;
    write_now && target == MBAM_T_CORE && eff_ofs == mbam_pkg::OFS_FSR;
  endsequence

  property p_pc_wraps13;
    @(posedge CLK) disable iff (SRST)
    (pc_reg == mbam_pkg::PC_TOP) and s_q4_plain_step |=> pc_reg == mbam_pkg::RESET_VEC;
  endproperty
  a_pc_wraps13: assert property (p_pc_wraps13) else $error("pc did not roll over");

  property p_prog_impl;
    @(posedge CLK) disable iff (SRST) (PROG_ADDR & ~PROG_MASK) == 13'h0000;
  endproperty
  a_prog_impl: assert property (p_prog_impl) else $error("fetch outside implemented words");

  property p_prog_wrap;
    // stated as a modulo so it does not just restate the masking expression
    @(posedge CLK) disable iff (SRST) PROG_ADDR == pc_reg % (PROG_MASK + mbam_pkg::PC_STEP);
  endproperty
  a_prog_wrap: assert property (p_prog_wrap) else $error("fetch address not wrapped");

  property p_reset_vec;
    @(posedge CLK) SRST ##1 !SRST |-> PROG_ADDR == mbam_pkg::RESET_VEC [*4];
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("first fetch not at reset vector");

  property p_irq_vec;
    @(posedge CLK) disable iff (SRST)
    phase_reg == mbam_pkg::MBAM_Q4 && IRQ_TAKE |=> PROG_ADDR == mbam_pkg::IRQ_VEC;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt not sent to vector");

  property p_bank_direct;
    @(posedge CLK) disable iff (SRST)
    FILE_ADDR != mbam_pkg::OFS_INDIRECT |=> PERI_ADDR[mbam_pkg::OFS_W] == $past(BANK_SEL);
  endproperty
  a_bank_direct: assert property (p_bank_direct) else $error("bank bit not applied");

  property p_common_map;
    @(posedge CLK) disable iff (SRST)
    eff_addr >= mbam_pkg::COMMON_LO |->
      target == MBAM_T_RAM && ram_idx == 7'(eff_addr) - 7'(mbam_pkg::GPR0_LO);
  endproperty
  a_common_map: assert property (p_common_map) else $error("common window misplaced");

  property p_unimpl_zero;
    @(posedge CLK) disable iff (SRST)
    read_now && target == MBAM_T_NONE |=> FILE_RDATA == mbam_pkg::BYTE_ZERO;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero");

  property p_read_q2_only;
    @(posedge CLK) disable iff (SRST)
    phase_reg != mbam_pkg::MBAM_Q2 ##1 !SRST |-> $stable(FILE_RDATA);
  endproperty
  a_read_q2_only: assert property (p_read_q2_only) else $error("read outside quarter 2");

  property p_write_q4;
    @(posedge CLK) disable iff (SRST) s_q4_fsr_write |=> fsr_reg == $past(FILE_WDATA);
  endproperty
  a_write_q4: assert property (p_write_q4) else $error("quarter 4 write lost");

  property p_indirect;
    @(posedge CLK) disable iff (SRST)
    FILE_ADDR == mbam_pkg::OFS_INDIRECT |=> PERI_ADDR == $past(fsr_reg);
  endproperty
  a_indirect: assert property (p_indirect) else $error("offset 00h not redirected");
endmodule : mbam_top

/* tb/mbam_core_model.sv */
`timescale 1ns/1ns
module mbam_core_model (
  // clock and quarter
  input  wire logic        clk,
  input  wire logic [1:0]  phase_q,
  // fetch requests
  output logic             jump_req,
  output logic [10:0]      jump_addr,
  output logic             irq_take,
  input  wire logic [12:0] prog_addr,
  // file access
  output logic [6:0]       file_addr,
  output logic             file_we,
  output logic [7:0]       file_wdata,
  input  wire logic [7:0]  file_rdata,
  // peripheral port
  input  wire logic [7:0]  peri_addr,
  input  wire logic        peri_we,
  input  wire logic [7:0]  peri_wdata,
  output logic [7:0]       peri_rdata
);
  int unsigned we_cnt;
  logic [7:0]  we_addr;
  logic [7:0]  we_data;

  initial begin
    we_cnt     = 0;
    jump_req   = 1'b0;
    jump_addr  = 11'h000;
    irq_take   = 1'b0;
    file_addr  = 7'h00;
    file_we    = 1'b0;
    file_wdata = 8'h00;
  end

  // address-dependent so a stale or wrong address shows up as wrong data
  assign peri_rdata = peri_addr ^ 8'hA5;

  always @(posedge clk) begin
    if (peri_we === 1'b1) begin
      we_cnt  <= we_cnt + 1;
      we_addr <= peri_addr;
      we_data <= peri_wdata;
    end
  end

  // one instruction cycle; inputs held Q1..Q4, operand taken in Q3, next fetch in Q1
  task automatic instr(input logic [6:0] a, input logic we, input logic [7:0] wd,
                       input logic jmp, input logic [10:0] ja, input logic irq,
                       output logic [7:0] rd, output logic [12:0] pc, output logic ok);
    int n;
    n = 0;
    while (phase_q !== 2'h0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    ok         = (n < 8);
    file_addr  = a;
    file_we    = we;
    file_wdata = wd;
    jump_req   = jmp;
    jump_addr  = ja;
    irq_take   = irq;
    repeat (2) @(negedge clk);
    rd = file_rdata;
    repeat (2) @(negedge clk);
    pc = prog_addr;
  endtask : instr
endmodule : mbam_core_model

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        srst;
  logic        jump_req;
  logic [10:0] jump_addr;
  logic        irq_take;
  logic [12:0] prog_addr;
  logic        fetch_stb;
  logic [1:0]  phase_q;
  logic [6:0]  file_addr;
  logic        file_we;
  logic [7:0]  file_wdata;
  logic [7:0]  file_rdata;
  logic        bank_sel;
  logic [7:0]  peri_rdata;
  logic [7:0]  peri_addr;
  logic        peri_we;
  logic [7:0]  peri_wdata;
  int          error_cnt;
  int          samples_checked;
  int          cycles;
  int          op_cnt;
  int          fetch_cnt;
  logic [12:0] pc_exp;
  logic [4:0]  latch_exp;
  logic        bank_exp;
  logic [7:0]  rd;

  mbam_top #(.LARGE_PROG(1'b1)) DUT (
    .CLK(clk), .SRST(srst), .JUMP_REQ(jump_req), .JUMP_ADDR(jump_addr),
    .IRQ_TAKE(irq_take), .PROG_ADDR(prog_addr), .FETCH_STB(fetch_stb), .PHASE_Q(phase_q),
    .FILE_ADDR(file_addr), .FILE_WE(file_we), .FILE_WDATA(file_wdata),
    .FILE_RDATA(file_rdata), .BANK_SEL(bank_sel), .PERI_RDATA(peri_rdata),
    .PERI_ADDR(peri_addr), .PERI_WE(peri_we), .PERI_WDATA(peri_wdata)
  );

  mbam_core_model core (
    .clk(clk), .phase_q(phase_q), .jump_req(jump_req), .jump_addr(jump_addr),
    .irq_take(irq_take), .prog_addr(prog_addr), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .file_rdata(file_rdata),
    .peri_addr(peri_addr), .peri_we(peri_we), .peri_wdata(peri_wdata),
    .peri_rdata(peri_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic fail(input string msg);
    error_cnt++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : fail

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
  endtask : cmp_byte

  task automatic cmp_addr(input logic [12:0] got, input logic [12:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
  endtask : cmp_addr

  // every cycle also checks the fetch address and the bank bit it should leave
  task automatic op(input logic [6:0] a, input logic we, input logic [7:0] wd,
                    input logic jmp, input logic [10:0] ja, input logic irq);
    logic [12:0] pc;
    logic        ok;
    core.instr(a, we, wd, jmp, ja, irq, rd, pc, ok);
    op_cnt++;
    if (!ok) fail("no first quarter seen");
    if (irq) pc_exp = mbam_pkg::IRQ_VEC;
    else if (we && a == mbam_pkg::OFS_PCL) pc_exp = {latch_exp, wd};
    else if (jmp) pc_exp = {latch_exp[4:3], ja};
    else pc_exp = pc_exp + 13'h0001;
    if (we && a == mbam_pkg::OFS_PC_HIGH_LATCH) latch_exp = wd[4:0];
    if (we && a == mbam_pkg::OFS_STATUS) bank_exp = wd[5];
    cmp_addr(pc, pc_exp & mbam_pkg::PROG_MASK_LARGE, "fetch address");
    cmp_byte({7'h00, bank_sel}, {7'h00, bank_exp}, "bank select");
  endtask : op

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    op(a, 1'b1, d, 1'b0, 11'h000, 1'b0);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    op(a, 1'b0, 8'h00, 1'b0, 11'h000, 1'b0);
    cmp_byte(rd, exp, "file read");
  endtask : rd_chk

  initial begin
    error_cnt       = 0;
    samples_checked = 0;
    cycles          = 0;
    op_cnt          = 0;
    fetch_cnt       = 0;
    pc_exp          = 13'h0000;
    latch_exp       = 5'h00;
    bank_exp        = 1'b0;
    srst            = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    cmp_addr(prog_addr, 13'h0000, "reset fetch address");
    rd_chk(7'h03, 8'h18);
    wr(7'h20, 8'h11);
    wr(7'h03, 8'h38);
    rd_chk(7'h03, 8'h38);
    wr(7'h20, 8'h22);
    wr(7'h70, 8'h5A);
    wr(7'h40, 8'h77);
    rd_chk(7'h40, 8'h00);
    wr(7'h0B, 8'hC6);
    wr(7'h01, 8'h3C);
    cmp_byte(8'(core.we_cnt), 8'h01, "peripheral writes");
    cmp_byte(core.we_addr, 8'h81, "peripheral address");
    cmp_byte(core.we_data, 8'h3C, "peripheral data");
    wr(7'h04, 8'hA0);
    wr(7'h03, 8'h18);
    rd_chk(7'h0B, 8'hC6);
    rd_chk(7'h04, 8'hA0);
    rd_chk(7'h00, 8'h22);
    wr(7'h00, 8'h33);
    rd_chk(7'h70, 8'h5A);
    rd_chk(7'h20, 8'h11);
    rd_chk(7'h06, 8'h00);
    rd_chk(7'h01, 8'hA4);
    wr(7'h1E, 8'h99);
    cmp_byte(8'(core.we_cnt), 8'h01, "read-only write passed");
    wr(7'h03, 8'h20);
    rd_chk(7'h20, 8'h33);
    wr(7'h03, 8'h00);
    wr(7'h04, 8'h00);
    rd_chk(7'h00, 8'h00);
    wr(7'h0A, 8'h08);
    op(7'h20, 1'b0, 8'h00, 1'b1, 11'h7FF, 1'b0);
    op(7'h20, 1'b0, 8'h00, 1'b0, 11'h000, 1'b0);
    op(7'h20, 1'b0, 8'h00, 1'b1, 11'h123, 1'b1);
    wr(7'h0A, 8'h18);
    wr(7'h02, 8'hC3);
    op(7'h20, 1'b0, 8'h00, 1'b0, 11'h000, 1'b0);
    wr(7'h0A, 8'h1F);
    wr(7'h02, 8'hFF);
    rd_chk(7'h20, 8'h11);
    wr(7'h03, 8'h20);
    // second reset in mid-run, with bank 1 selected beforehand
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst      = 1'b0;
    pc_exp    = 13'h0000;
    latch_exp = 5'h00;
    bank_exp  = 1'b0;
    cmp_addr(prog_addr, 13'h0000, "second reset fetch address");
    rd_chk(7'h03, 8'h18);
    cmp_byte(8'(fetch_cnt), 8'(op_cnt), "fetch strobes");
    complete_run();
  end

  // the whole sequence needs about one hundred and sixty cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (fetch_stb === 1'b1) begin
      fetch_cnt <= fetch_cnt + 1;
    end
    if (cycles == 2000) begin
      fail("run did not finish");
      complete_run();
    end
  end
endmodule : tb
